// ==== sprite_plane_pkg.sv ====
package sprite_plane_pkg;
    localparam logic [31:0] OFF_LINEAR   = 32'h00072384;
    localparam logic [31:0] OFF_STRIDE   = 32'h00072388;
    localparam logic [31:0] OFF_POSITION = 32'h0007238c;
    localparam logic [31:0] OFF_SIZE     = 32'h00072390;
    localparam logic [31:0] OFF_KEYMIN   = 32'h00072394;
    localparam logic [31:0] OFF_KEYMASK  = 32'h00072398;
    localparam logic [31:0] OFF_SURFACE  = 32'h0007239c;
    localparam logic [31:0] RESET_VALUE  = 32'h00000000;
    localparam logic [31:0] POS_MASK     = 32'h0fff0fff;
    localparam logic [31:0] STRIDE_MASK  = 32'hffffffc0;
    localparam logic [31:0] KEYMIN_MASK  = 32'h00ffffff;
    localparam logic [31:0] KEYMSK_MASK  = 32'h00000007;
    localparam logic [31:0] SURF_MASK    = 32'hfffff008;
    localparam logic [31:0] BASE_MASK    = 32'hfffff000;
    localparam int          CTL_TILED    = 10;
    localparam int          CTL_KEYEN    = 22;
    localparam int          SURF_SRC_BIT = 3;
    localparam int          CTL_ORDER    = 0;
    localparam int          CTL_BOTTOM   = 2;
    // second sprite bits sit in reserved slots, clear of the tiled bit
    localparam int          CTL_SEC_ORDER  = 4;
    localparam int          CTL_SEC_BOTTOM = 6;
    // plane codes in the stack output
    localparam logic [1:0] PLANE_PRIMARY = 2'h0;
    localparam logic [1:0] PLANE_THIS    = 2'h1;
    localparam logic [1:0] PLANE_SECOND  = 2'h2;
    localparam logic [1:0] PLANE_CURSOR  = 2'h3;
endpackage : sprite_plane_pkg

// ==== sprite_plane_if.sv ====
`timescale 1ns/1ps
interface sprite_plane_if;
    logic        wrEn;
    logic        rdEn;
    logic [31:0] addr;
    logic [31:0] wrData;
    logic [31:0] rdData;
    logic        rdValid;
    logic        vblank;
    logic [31:0] ctlWord;
    logic        flipDoneRender;
    logic        flipDoneBlitter;
    modport device (input wrEn, rdEn, addr, wrData, vblank, ctlWord,
                    output rdData, rdValid, flipDoneRender,
                    flipDoneBlitter);
    modport host (output wrEn, rdEn, addr, wrData, vblank, ctlWord,
                  input rdData, rdValid, flipDoneRender, flipDoneBlitter);
endinterface : sprite_plane_if

// ==== sprite_plane_host.sv ====
`timescale 1ns/1ps
// host end: forwards user register writes in order, drives blank timing
module sprite_plane_host (
    input  wire logic        core_clk,
    input  wire logic        rst,
    sprite_plane_if.host     bus,
    input  wire logic        reqWrite,
    input  wire logic        reqRead,
    input  wire logic [31:0] reqAddr,
    input  wire logic [31:0] reqData,
    input  wire logic        vblankIn,
    input  wire logic [31:0] ctlIn,
    output logic [31:0]      readData,
    output logic             readValid,
    output logic             flipDone,
    output logic             flipFromBlitter
);
    typedef struct packed {
        logic        wrEn;
        logic        rdEn;
        logic [31:0] addr;
        logic [31:0] wrData;
        logic        vblank;
        logic [31:0] ctl;
        logic [31:0] readData;
        logic        readValid;
        logic        flipDone;
        logic        flipBlt;
    } host_state_t;
    host_state_t s_q;
    host_state_t s_d;

    always_comb begin
        s_d = s_q;
        // stride before surface and surface last is the caller's duty
        s_d.wrEn = reqWrite;
        s_d.rdEn = reqRead & ~reqWrite;
        s_d.addr = reqAddr;
        s_d.wrData = reqData;
        s_d.vblank = vblankIn;
        s_d.ctl = ctlIn;
        s_d.readValid = bus.rdValid;
        if (bus.rdValid) begin
            s_d.readData = bus.rdData;
        end
        s_d.flipDone = bus.flipDoneRender | bus.flipDoneBlitter;
        s_d.flipBlt = bus.flipDoneBlitter;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.wrEn = s_q.wrEn;
    assign bus.rdEn = s_q.rdEn;
    assign bus.addr = s_q.addr;
    assign bus.wrData = s_q.wrData;
    assign bus.vblank = s_q.vblank;
    assign bus.ctlWord = s_q.ctl;
    assign readData = s_q.readData;
    assign readValid = s_q.readValid;
    assign flipDone = s_q.flipDone;
    assign flipFromBlitter = s_q.flipBlt;
endmodule : sprite_plane_host

// ==== sprite_plane_device.sv ====
`timescale 1ns/1ps
module sprite_plane_device (
    input  wire logic        core_clk,
    input  wire logic        rst,
    sprite_plane_if.device   bus,
    input  wire logic [23:0] pixelIn,
    input  wire logic        pixelIsYuv,
    input  wire logic [23:0] keyMaxIn,
    output logic [31:0]      fetchAddr,
    output logic [31:0]      activeStride,
    output logic [31:0]      activePosition,
    output logic [31:0]      activeSize,
    output logic [7:0]       planeStack,
    output logic             keyOnThis,
    output logic             keyOnSecond,
    output logic             orderIllegal,
    output logic             pixelTransparent
);
    typedef struct packed {
        logic [31:0] linP;
        logic [31:0] strideP;
        logic [31:0] posP;
        logic [31:0] sizeP;
        logic [31:0] keyMinP;
        logic [31:0] keyMskP;
        logic [31:0] surfP;
        logic [31:0] linA;
        logic [31:0] strideA;
        logic [31:0] posA;
        logic [31:0] sizeA;
        logic [31:0] keyMinA;
        logic [31:0] keyMskA;
        logic [31:0] surfA;
        logic        armed;
        logic        linPending;
        logic        vbPrev;
        logic [31:0] rdData;
        logic        rdValid;
        logic        doneRcs;
        logic        doneBcs;
        logic [31:0] fetch;
        logic [7:0]  stack;
        logic        keyThis;
        logic        keySecond;
        logic        illegal;
        logic        transp;
    } dev_state_t;
    dev_state_t s_q;
    dev_state_t s_d;

    logic        vbRise;
    logic [3:0]  zsel;
    logic [2:0]  chanHit;
    logic        keyMatch;
    logic [23:0] keyMin;
    logic [23:0] msk24;

    assign vbRise = bus.vblank & ~s_q.vbPrev;
    assign keyMin = s_q.keyMinA[23:0];
    assign msk24 = {{8{s_q.keyMskA[2]}}, {8{s_q.keyMskA[1]}},
                    {8{s_q.keyMskA[0]}}};
    assign zsel = {bus.ctlWord[sprite_plane_pkg::CTL_ORDER],
                   bus.ctlWord[sprite_plane_pkg::CTL_BOTTOM],
                   bus.ctlWord[sprite_plane_pkg::CTL_SEC_ORDER],
                   bus.ctlWord[sprite_plane_pkg::CTL_SEC_BOTTOM]};

    // second sprite bits avoid bit 10 so z-order never flips tiling
    generate
        for (genvar c = 0; c < 3; c++) begin : g_chan
            always_comb begin
                if (pixelIsYuv) begin
                    chanHit[c] = ~s_q.keyMskA[c] |
                        ((pixelIn[c*8 +: 8] >= keyMin[c*8 +: 8]) &&
                         (pixelIn[c*8 +: 8] <= keyMaxIn[c*8 +: 8]));
                end else begin
                    chanHit[c] = 1'b1;
                end
            end
        end
    endgenerate

    always_comb begin
        if (pixelIsYuv) begin
            keyMatch = &chanHit;
        end else begin
            keyMatch = ((pixelIn ^ keyMin) & msk24) == 24'h000000;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.vbPrev = bus.vblank;
        s_d.rdValid = 1'b0;
        s_d.doneRcs = 1'b0;
        s_d.doneBcs = 1'b0;
        if (bus.rdEn) begin
            s_d.rdValid = 1'b1;
            unique case (bus.addr)
                sprite_plane_pkg::OFF_LINEAR:   s_d.rdData = s_q.linP;
                sprite_plane_pkg::OFF_STRIDE:   s_d.rdData = s_q.strideP;
                sprite_plane_pkg::OFF_POSITION: s_d.rdData = s_q.posP;
                sprite_plane_pkg::OFF_SIZE:     s_d.rdData = s_q.sizeP;
                sprite_plane_pkg::OFF_KEYMIN:   s_d.rdData = s_q.keyMinP;
                sprite_plane_pkg::OFF_KEYMASK:  s_d.rdData = s_q.keyMskP;
                sprite_plane_pkg::OFF_SURFACE:  s_d.rdData = s_q.surfP;
                default: s_d.rdData = sprite_plane_pkg::RESET_VALUE;
            endcase
        end
        if (bus.wrEn) begin
            unique case (bus.addr)
                sprite_plane_pkg::OFF_LINEAR: begin
                    s_d.linP = bus.wrData;
                    s_d.linPending = 1'b1;
                end
                sprite_plane_pkg::OFF_STRIDE:
                    s_d.strideP = bus.wrData &
                        sprite_plane_pkg::STRIDE_MASK;
                sprite_plane_pkg::OFF_POSITION:
                    s_d.posP = bus.wrData & sprite_plane_pkg::POS_MASK;
                sprite_plane_pkg::OFF_SIZE:
                    s_d.sizeP = bus.wrData & sprite_plane_pkg::POS_MASK;
                sprite_plane_pkg::OFF_KEYMIN:
                    s_d.keyMinP = bus.wrData &
                        sprite_plane_pkg::KEYMIN_MASK;
                sprite_plane_pkg::OFF_KEYMASK:
                    s_d.keyMskP = bus.wrData &
                        sprite_plane_pkg::KEYMSK_MASK;
                sprite_plane_pkg::OFF_SURFACE: begin
                    s_d.surfP = bus.wrData &
                        sprite_plane_pkg::SURF_MASK;
                    s_d.armed = 1'b1;
                end
                default: ;
            endcase
        end
        // offset follows vsync alone, not the flip trigger
        if (vbRise && s_q.linPending) begin
            s_d.linA = s_q.linP;
            s_d.linPending = bus.wrEn &&
                (bus.addr == sprite_plane_pkg::OFF_LINEAR);
        end
        if (vbRise) begin
            s_d.posA = s_q.posP;
        end
        if (vbRise && s_q.armed) begin
            s_d.strideA = s_q.strideP;
            s_d.sizeA = s_q.sizeP;
            s_d.keyMinA = s_q.keyMinP;
            s_d.keyMskA = s_q.keyMskP;
            s_d.surfA = s_q.surfP;
            // a trigger landing on this edge stays armed for the next
            s_d.armed = bus.wrEn &&
                (bus.addr == sprite_plane_pkg::OFF_SURFACE);
            s_d.doneRcs = ~s_q.surfP[sprite_plane_pkg::SURF_SRC_BIT];
            s_d.doneBcs = s_q.surfP[sprite_plane_pkg::SURF_SRC_BIT];
        end
        if (bus.ctlWord[sprite_plane_pkg::CTL_TILED]) begin
            s_d.fetch = s_q.surfA & sprite_plane_pkg::BASE_MASK;
        end else begin
            s_d.fetch = (s_q.surfA & sprite_plane_pkg::BASE_MASK) +
                s_q.linA;
        end
        s_d.illegal = 1'b0;
        s_d.keyThis = 1'b0;
        s_d.keySecond = 1'b0;
        // stack packs bottom plane in the low two bits
        unique case (zsel)
            4'b0000: s_d.stack = {sprite_plane_pkg::PLANE_CURSOR,
                sprite_plane_pkg::PLANE_SECOND, sprite_plane_pkg::PLANE_THIS,
                sprite_plane_pkg::PLANE_PRIMARY};
            4'b1000: s_d.stack = {sprite_plane_pkg::PLANE_CURSOR,
                sprite_plane_pkg::PLANE_THIS, sprite_plane_pkg::PLANE_SECOND,
                sprite_plane_pkg::PLANE_PRIMARY};
            4'b0001, 4'b0011: begin
                s_d.stack = {sprite_plane_pkg::PLANE_CURSOR,
                    sprite_plane_pkg::PLANE_THIS,
                    sprite_plane_pkg::PLANE_PRIMARY,
                    sprite_plane_pkg::PLANE_SECOND};
                s_d.keySecond = 1'b1;
            end
            4'b1001, 4'b1011: begin
                s_d.stack = {sprite_plane_pkg::PLANE_CURSOR,
                    sprite_plane_pkg::PLANE_PRIMARY,
                    sprite_plane_pkg::PLANE_THIS,
                    sprite_plane_pkg::PLANE_SECOND};
                s_d.keyThis = 1'b1;
            end
            4'b0100: begin
                s_d.stack = {sprite_plane_pkg::PLANE_CURSOR,
                    sprite_plane_pkg::PLANE_SECOND,
                    sprite_plane_pkg::PLANE_PRIMARY,
                    sprite_plane_pkg::PLANE_THIS};
                s_d.keyThis = 1'b1;
            end
            4'b0110, 4'b1110, 4'b0010: begin
                s_d.stack = {sprite_plane_pkg::PLANE_CURSOR,
                    sprite_plane_pkg::PLANE_PRIMARY,
                    sprite_plane_pkg::PLANE_SECOND,
                    sprite_plane_pkg::PLANE_THIS};
                s_d.keySecond = 1'b1;
            end
            default: begin
                // forbidden combinations load the 4'b0000 stacking and flag illegal
                s_d.stack = {sprite_plane_pkg::PLANE_CURSOR,
                    sprite_plane_pkg::PLANE_SECOND,
                    sprite_plane_pkg::PLANE_THIS,
                    sprite_plane_pkg::PLANE_PRIMARY};
                s_d.illegal = 1'b1;
            end
        endcase
        s_d.transp = bus.ctlWord[sprite_plane_pkg::CTL_KEYEN] &
            keyMatch;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.rdData = s_q.rdData;
    assign bus.rdValid = s_q.rdValid;
    assign bus.flipDoneRender = s_q.doneRcs;
    assign bus.flipDoneBlitter = s_q.doneBcs;
    assign fetchAddr = s_q.fetch;
    assign activeStride = s_q.strideA;
    assign activePosition = s_q.posA;
    assign activeSize = s_q.sizeA;
    assign planeStack = s_q.stack;
    assign keyOnThis = s_q.keyThis;
    assign keyOnSecond = s_q.keySecond;
    assign orderIllegal = s_q.illegal;
    assign pixelTransparent = s_q.transp;
endmodule : sprite_plane_device

// ==== sprite_plane_assertions.sv ====
`timescale 1ns/1ps
module sprite_plane_assertions (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        wrEn,
    input  wire logic        rdEn,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wrData,
    input  wire logic [31:0] rdData,
    input  wire logic        rdValid,
    input  wire logic        vblank,
    input  wire logic [31:0] ctlWord,
    input  wire logic        flipDoneRender,
    input  wire logic        flipDoneBlitter
);
    logic [31:0] shadow_q [1:7];
    logic        armed_q;
    logic        src_q;
    logic        vPrev_q;
    logic        mapped;
    logic        rise;
    logic        trig;
    logic [31:0] mask;
    logic [31:0] rdExp;
    assign mapped = addr[1:0] == 2'h0 && addr >= sprite_plane_pkg::OFF_LINEAR
                    && addr <= sprite_plane_pkg::OFF_SURFACE;
    assign rise = vblank && !vPrev_q;
    assign trig = rise && armed_q;
    always_comb begin
        case (addr[4:2])
            3'h2: mask = sprite_plane_pkg::STRIDE_MASK;
            3'h3, 3'h4: mask = sprite_plane_pkg::POS_MASK;
            3'h5: mask = sprite_plane_pkg::KEYMIN_MASK;
            3'h6: mask = sprite_plane_pkg::KEYMSK_MASK;
            3'h7: mask = sprite_plane_pkg::SURF_MASK;
            default: mask = 32'hffffffff;
        endcase
        rdExp = mapped ? shadow_q[addr[4:2]] : 32'h0;
    end
    // mirror of the pending copies; a surface write arms one flip
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            armed_q <= 1'b0;
            src_q <= 1'b0;
            vPrev_q <= 1'b0;
            for (int i = 1; i < 8; i++) shadow_q[i] <= 32'h0;
        end else begin
            vPrev_q <= vblank;
            if (wrEn && mapped) shadow_q[addr[4:2]] <= wrData & mask;
            if (wrEn && addr == sprite_plane_pkg::OFF_SURFACE) begin
                armed_q <= 1'b1;
                src_q <= wrData[3];
            end else if (rise) begin
                armed_q <= 1'b0;
            end
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_read_answer: assert property (rdEn && !wrEn |=> rdValid)
        else $error("read not answered in one cycle");
    a_valid_cause: assert property (rdValid |-> $past(rdEn))
        else $error("read answer without request");
    a_read_data: assert property (
        rdEn && !wrEn && mapped |=> rdData == $past(rdExp))
        else $error("read data differs from pending copy");
    a_unmapped_zero: assert property (
        rdEn && !wrEn && !mapped |=> rdData == 32'h0)
        else $error("unmapped read not zero");
    a_flip_render: assert property (
        trig && !src_q |=> flipDoneRender && !flipDoneBlitter)
        else $error("render flip answer missing");
    a_flip_blitter: assert property (
        trig && src_q |=> flipDoneBlitter && !flipDoneRender)
        else $error("blitter flip answer missing");
    a_flip_cause: assert property (
        flipDoneRender || flipDoneBlitter |-> $past(trig))
        else $error("flip answer without armed blank");
    a_flip_pulse: assert property (flipDoneRender |=> !flipDoneRender)
        else $error("flip answer longer than one cycle");
endmodule : sprite_plane_assertions

// ==== tb_sprite_plane_surface_keying.sv ====
`timescale 1ns/1ps
module tb_sprite_plane_surface_keying;
    typedef struct packed {
        logic        blit;
        logic [31:0] stride, pos, size, fetch;
    } flip_note_t;
    logic        core_clk, rst, reqWrite, reqRead, vblankIn, pixelIsYuv;
    logic        readValid, flipDone, flipFromBlitter, m;
    logic        keyOnThis, keyOnSecond, orderIllegal, pixelTransparent;
    logic [31:0] reqAddr, reqData, ctlIn, readData, fetchAddr;
    logic [31:0] activeStride, activePosition, activeSize;
    logic [23:0] pixelIn, keyMaxIn, kmin, bm;
    logic [7:0]  planeStack;
    logic [15:0] zt [12];
    logic [31:0] v [1:8];
    logic [31:0] mk [1:8];
    logic [31:0] rdQ [$];
    flip_note_t  flipQ [$];
    flip_note_t  note;
    int          n_errors, checks_done, cyc, seed;
    sprite_plane_if bus ();
    sprite_plane_host u_sprite_plane_host (.core_clk, .rst, .bus(bus.host),
        .reqWrite, .reqRead, .reqAddr, .reqData, .vblankIn, .ctlIn,
        .readData, .readValid, .flipDone, .flipFromBlitter);
    sprite_plane_device u_sprite_plane_device (.core_clk, .rst,
        .bus(bus.device), .pixelIn, .pixelIsYuv, .keyMaxIn, .fetchAddr,
        .activeStride, .activePosition, .activeSize, .planeStack,
        .keyOnThis, .keyOnSecond, .orderIllegal, .pixelTransparent);
    sprite_plane_assertions u_sprite_plane_assertions (.core_clk, .rst,
        .wrEn(bus.wrEn), .rdEn(bus.rdEn), .addr(bus.addr),
        .wrData(bus.wrData),
        .rdData(bus.rdData), .rdValid(bus.rdValid), .vblank(bus.vblank),
        .ctlWord(bus.ctlWord), .flipDoneRender(bus.flipDoneRender),
        .flipDoneBlitter(bus.flipDoneBlitter));
    initial core_clk = 1'b0;
    always #4 core_clk = ~core_clk;
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick
    // strobes drop for a cycle so no signal is set twice in one step
    task automatic wr(input logic [31:0] a, d);
        reqWrite = 1'b1; reqAddr = a; reqData = d; tick(1);
        reqWrite = 1'b0; tick(1);
    endtask : wr
    task automatic rd(input logic [31:0] a, e);
        reqRead = 1'b1; reqAddr = a; rdQ.push_back(e); tick(1);
        reqRead = 1'b0; tick(1);
    endtask : rd
    task automatic vbl();
        tick(3); vblankIn = 1'b1; tick(2); vblankIn = 1'b0; tick(5);
    endtask : vbl
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        forever begin
            @(negedge core_clk);
            if (readValid === 1'b1)
                chk("readData", readData, rdQ.pop_front());
            if (flipDone === 1'b1) begin
                note = flipQ.pop_front();
                chk("flipSource", flipFromBlitter, note.blit);
                tick(2);
                chk("stride", activeStride, note.stride);
                chk("position", activePosition, note.pos);
                chk("size", activeSize, note.size);
                chk("fetchAddr", fetchAddr, note.fetch);
            end
        end
    end
    initial begin
        rst = 1'b1; reqWrite = 1'b0; reqRead = 1'b0; reqAddr = 32'h0;
        reqData = 32'h0; vblankIn = 1'b0; ctlIn = 32'h0; pixelIn = 24'h0;
        pixelIsYuv = 1'b0; keyMaxIn = 24'h0; seed = 15901;
        mk = '{32'hffffffff, sprite_plane_pkg::STRIDE_MASK,
               sprite_plane_pkg::POS_MASK, sprite_plane_pkg::POS_MASK,
               sprite_plane_pkg::KEYMIN_MASK, sprite_plane_pkg::KEYMSK_MASK,
               sprite_plane_pkg::SURF_MASK, 32'h0};
        // combo, stack bottom-first, illegal, key on this, key on second
        zt = '{16'h0e40, 16'h8d80, 16'h1d21, 16'h3d21, 16'h9c62, 16'h4e12,
               16'hec91, 16'h5008, 16'h7008, 16'hd008, 16'hf008, 16'ha008};
        tick(8); rst = 1'b0; tick(2);
        for (int i = 1; i < 9; i++) rd(32'h72380 + 32'(4 * i), 32'h0);
        for (int r = 0; r < 2; r++) begin
            foreach (v[i]) v[i] = $random(seed);
            v[7][3] = r[0];
            for (int i = 1; i < 8; i++) wr(32'h72380 + 32'(4 * i), v[i]);
            for (int i = 1; i < 9; i++)
                rd(32'h72380 + 32'(4 * i), v[i] & mk[i]);
            flipQ.push_back('{r[0], v[2] & mk[2], v[3] & mk[3],
                v[4] & mk[4], (v[7] & sprite_plane_pkg::BASE_MASK) + v[1]});
            vbl();
        end
        wr(32'h72388, 32'h1100); wr(32'h7238c, 32'h200010);
        wr(32'h72384, 32'h100); tick(4);
        chk("heldFetch", fetchAddr, note.fetch);
        vbl();
        chk("posOnly", activePosition, 32'h200010);
        chk("strideHeld", activeStride, note.stride);
        chk("newOffset", fetchAddr, (v[7] & 32'hfffff000) + 32'h100);
        ctlIn = 32'h400; wr(32'h7239c, 32'h12345000);
        flipQ.push_back('{1'b0, 32'h1100, 32'h200010, note.size,
            32'h12345000});
        vbl();
        kmin = $random(seed);
        ctlIn = 32'h400004; wr(32'h72394, {8'h0, kmin}); wr(32'h72398, 32'h5);
        wr(32'h7239c, 32'h12345000);
        flipQ.push_back('{1'b0, 32'h1100, 32'h200010, note.size,
            32'h12345100});
        vbl();
        bm = 24'hff00ff;
        for (int k = 0; k < 300; k++) begin
            // host stage delays the control word, so keying stops at 150
            if (k == 149) ctlIn = 32'h4;
            pixelIsYuv = $random(seed);
            keyMaxIn = kmin | 24'($random(seed));
            case ($unsigned($random(seed)) % 3)
                0: pixelIn = kmin;
                1: pixelIn = kmin ^ (24'($random(seed)) & 24'h00ff00);
                default: pixelIn = 24'($random(seed));
            endcase
            m = ((pixelIn ^ kmin) & bm) == 24'h0;
            if (pixelIsYuv) begin
                m = 1'b1;
                for (int c = 0; c < 3; c += 2)
                    if (pixelIn[8*c+:8] < kmin[8*c+:8] ||
                        pixelIn[8*c+:8] > keyMaxIn[8*c+:8]) m = 1'b0;
            end
            tick(1);
            chk("transparent", pixelTransparent, m && k < 150);
        end
        foreach (zt[i]) begin
            ctlIn = {21'h2, 4'h0, zt[i][12], 1'b0, zt[i][13], 1'b0,
                     zt[i][14], 1'b0, zt[i][15]};
            tick(4);
            chk("illegal", orderIllegal, zt[i][3]);
            if (!zt[i][3]) begin
                chk("stack", planeStack, zt[i][11:4]);
                chk("keyThis", keyOnThis, zt[i][1]);
                chk("keySecond", keyOnSecond, zt[i][0]);
            end
        end
        tick(10);
        chk("pending", rdQ.size() + flipQ.size(), 32'h0);
        stop_test();
    end
endmodule : tb_sprite_plane_surface_keying
